// >>> rtl/pad_cfg_pkg.sv
// Purpose: constants for the pad mode and output rail select block
// Assumes: avalon-mm slave, 32-bit data, byte addresses
// Notes: some printed offsets are not multiples of four, so they are kept as indices
`default_nettype none
package pad_cfg_pkg;
   localparam int ADDR_W = 32;
   localparam int DATA_W = 32;
   localparam int REG_W = 16;
   localparam int NUM_MODE = 4;
   // printed offsets serve as register indices; byte address is four times the index
   localparam logic [31:0] IDX_PIN6_MODE = 32'h50003052;
   localparam logic [31:0] IDX_PIN7_MODE = 32'h50003054;
   localparam logic [31:0] IDX_PIN8_MODE = 32'h50003056;
   localparam logic [31:0] IDX_PIN9_MODE = 32'h50003058;
   localparam logic [31:0] IDX_RAIL_SEL = 32'h50003070;
   localparam logic [31:0] IDX_PAD_STATUS = 32'h50003071;
   localparam logic [31:0] IDX_ANALOG_CTRL = 32'h50003073;
   // field layout of a pin mode register
   localparam int DIR_PULL_LSB = 8;
   localparam int DIR_PULL_MSB = 9;
   localparam int FUNC_SEL_LSB = 0;
   localparam int FUNC_SEL_MSB = 4;
   localparam logic [1:0] DIR_PULL_RST = 2'h2;
   localparam logic [4:0] FUNC_SEL_RST = 5'h00;
   localparam logic [15:0] MODE_MASK = 16'h031f;
   // field layout of the rail select register
   localparam int PORT0_RAIL_LSB = 0;
   localparam int PORT0_RAIL_MSB = 7;
   localparam int PORT1_RAIL_LSB = 8;
   localparam int PORT1_RAIL_MSB = 13;
   localparam logic [15:0] RAIL_MASK = 16'h3fff;
   localparam logic [15:0] RAIL_RST = 16'h0000;
   // direction and pull encodings
   localparam logic [1:0] DP_IN_NONE = 2'h0;
   localparam logic [1:0] DP_IN_UP = 2'h1;
   localparam logic [1:0] DP_IN_DOWN = 2'h2;
   localparam logic [1:0] DP_OUT = 2'h3;
   localparam logic [31:0] UNMAPPED_READ = 32'h00000000;
   typedef enum logic [1:0] {
      BUS_IDLE,
      BUS_ANSWER
   } bus_state_t;
endpackage : pad_cfg_pkg
`default_nettype wire

// >>> rtl/pad_mode_and_rail_select.sv
// Purpose: pin mode registers for port 2 pins 6..9 and the port 0/1 output rail select
// Assumes: avalon-mm master holds requests until waitrequest is low
// Notes: every access answers on the second edge after it is presented
`default_nettype none

// Summary of operation
// - each pin's two-bit field picks 00 input, 01 input pull-up, 10 input pull-down, 11 output.
// - after reset every pin's two-bit field holds 10, an input with pull-down.
// - a pin in analog mode ignores its two-bit field, so the pad sees no pull or drive.
// - rail select bits 13..8 steer port 1 pins 0..5 in order.
// - rail select bits 7..0 steer port 0 pins 0..7 in order.
// - a rail select bit at one feeds that pin's driver from the low-voltage rail.
// - a rail select bit at zero feeds it from the high-voltage rail, and all reset to zero.
// - four 16-bit mode registers for pins 6..9 sit at consecutive even offsets.
module pad_mode_and_rail_select
   import pad_cfg_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   input wire logic [ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [DATA_W-1:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [DATA_W-1:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic boost_mode,
   output logic [NUM_MODE-1:0] pin_pull_up_en,
   output logic [NUM_MODE-1:0] pin_pull_down_en,
   output logic [NUM_MODE-1:0] pin_output_en,
   output logic [NUM_MODE*5-1:0] pin_function_select,
   output logic [7:0] port0_rail_select,
   output logic [5:0] port1_rail_select,
   output logic rail_conflict
);

   bus_state_t state_ff, nxt_state;
   logic [DATA_W-1:0] rdata_ff, nxt_rdata;
   logic [15:0] mode_ff [NUM_MODE];
   logic [15:0] nxt_mode [NUM_MODE];
   logic [15:0] rail_ff, nxt_rail;
   logic [NUM_MODE-1:0] analog_ff, nxt_analog;
   logic [NUM_MODE-1:0] pull_up_ff, nxt_pull_up;
   logic [NUM_MODE-1:0] pull_down_ff, nxt_pull_down;
   logic [NUM_MODE-1:0] out_en_ff, nxt_out_en;
   logic [NUM_MODE*5-1:0] func_ff, nxt_func;
   logic [13:0] rail_out_ff, nxt_rail_out;
   logic conflict_ff, nxt_conflict;
   logic boost_s1_ff, boost_s2_ff, boost_s3_ff, boost_ff;
   logic nxt_boost;

   logic [15:0] wmask;
   logic [31:0] word_idx;
   logic req;

   assign req = avs_read | avs_write;
   assign wmask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
   // index top bits do not fit a byte address, so they come from the register base
   assign word_idx = {IDX_PIN6_MODE[31:30], avs_address[ADDR_W-1:2]};

   // bus: one cycle to decode, answer with waitrequest low on the next
   always_comb begin
      nxt_state = state_ff;
      nxt_rdata = rdata_ff;
      for (int i = 0; i < NUM_MODE; i++) begin
         nxt_mode[i] = mode_ff[i];
      end
      nxt_rail = rail_ff;
      nxt_analog = analog_ff;
      case (state_ff)
         BUS_IDLE: begin
            if (req) begin
               nxt_state = BUS_ANSWER;
               nxt_rdata = UNMAPPED_READ;
               if (word_idx == IDX_PIN6_MODE) begin
                  nxt_rdata = {16'h0000, mode_ff[0]};
               end else if (word_idx == IDX_PIN7_MODE) begin
                  nxt_rdata = {16'h0000, mode_ff[1]};
               end else if (word_idx == IDX_PIN8_MODE) begin
                  nxt_rdata = {16'h0000, mode_ff[2]};
               end else if (word_idx == IDX_PIN9_MODE) begin
                  nxt_rdata = {16'h0000, mode_ff[3]};
               end else if (word_idx == IDX_RAIL_SEL) begin
                  nxt_rdata = {16'h0000, rail_ff};
               end else if (word_idx == IDX_PAD_STATUS) begin
                  nxt_rdata = {28'h0000000, conflict_ff, boost_ff, out_en_ff[1:0]};
               end else if (word_idx == IDX_ANALOG_CTRL) begin
                  nxt_rdata = {{(DATA_W-NUM_MODE){1'b0}}, analog_ff};
               end
            end
         end
         BUS_ANSWER: begin
            nxt_state = BUS_IDLE;
            if (avs_write) begin
               if (word_idx == IDX_PIN6_MODE) begin
                  nxt_mode[0] = (mode_ff[0] & ~wmask) | (avs_writedata[15:0] & wmask & MODE_MASK);
               end else if (word_idx == IDX_PIN7_MODE) begin
                  nxt_mode[1] = (mode_ff[1] & ~wmask) | (avs_writedata[15:0] & wmask & MODE_MASK);
               end else if (word_idx == IDX_PIN8_MODE) begin
                  nxt_mode[2] = (mode_ff[2] & ~wmask) | (avs_writedata[15:0] & wmask & MODE_MASK);
               end else if (word_idx == IDX_PIN9_MODE) begin
                  nxt_mode[3] = (mode_ff[3] & ~wmask) | (avs_writedata[15:0] & wmask & MODE_MASK);
               end else if (word_idx == IDX_RAIL_SEL) begin
                  nxt_rail = (rail_ff & ~wmask) | (avs_writedata[15:0] & wmask & RAIL_MASK);
               end else if (word_idx == IDX_ANALOG_CTRL && avs_byteenable[0]) begin
                  nxt_analog = avs_writedata[NUM_MODE-1:0];
               end
            end
         end
         default: begin
            nxt_state = BUS_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         state_ff <= BUS_IDLE;
         rdata_ff <= 32'h00000000;
         for (int i = 0; i < NUM_MODE; i++) begin
            mode_ff[i] <= {6'h00, DIR_PULL_RST, 3'h0, FUNC_SEL_RST};
         end
         rail_ff <= RAIL_RST;
         analog_ff <= '0;
      end else begin
         state_ff <= nxt_state;
         rdata_ff <= nxt_rdata;
         for (int i = 0; i < NUM_MODE; i++) begin
            mode_ff[i] <= nxt_mode[i];
         end
         rail_ff <= nxt_rail;
         analog_ff <= nxt_analog;
      end
   end

   assign avs_waitrequest = (state_ff != BUS_ANSWER);
   assign avs_readdata = rdata_ff;

   // pad controls decoded from the mode fields
   always_comb begin
      logic [1:0] dp;
      dp = 2'h0;
      nxt_pull_up = '0;
      nxt_pull_down = '0;
      nxt_out_en = '0;
      nxt_func = '0;
      for (int i = 0; i < NUM_MODE; i++) begin
         dp = mode_ff[i][DIR_PULL_MSB:DIR_PULL_LSB];
         nxt_func[i*5 +: 5] = mode_ff[i][FUNC_SEL_MSB:FUNC_SEL_LSB];
         if (!analog_ff[i]) begin
            nxt_pull_up[i] = (dp == DP_IN_UP);
            nxt_pull_down[i] = (dp == DP_IN_DOWN);
            nxt_out_en[i] = (dp == DP_OUT);
         end
      end
      // bit at one picks the low rail, at zero the high rail
      nxt_rail_out = rail_ff[PORT1_RAIL_MSB:PORT0_RAIL_LSB];
      // low-rail request while the converter is not boosting is flagged
      nxt_conflict = (|rail_ff[PORT1_RAIL_MSB:PORT0_RAIL_LSB]) && !boost_ff;
   end

   // boost strap from the supply domain passes three flops, then a fourth that loads only when the last two agree
   always_comb begin
      nxt_boost = boost_ff;
      if (boost_s2_ff == boost_s3_ff) begin
         nxt_boost = boost_s3_ff;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         pull_up_ff <= '0;
         pull_down_ff <= '0;
         out_en_ff <= '0;
         func_ff <= '0;
         rail_out_ff <= '0;
         conflict_ff <= 1'b0;
         boost_s1_ff <= 1'b0;
         boost_s2_ff <= 1'b0;
         boost_s3_ff <= 1'b0;
         boost_ff <= 1'b0;
      end else begin
         pull_up_ff <= nxt_pull_up;
         pull_down_ff <= nxt_pull_down;
         out_en_ff <= nxt_out_en;
         func_ff <= nxt_func;
         rail_out_ff <= nxt_rail_out;
         conflict_ff <= nxt_conflict;
         boost_s1_ff <= boost_mode;
         boost_s2_ff <= boost_s1_ff;
         boost_s3_ff <= boost_s2_ff;
         boost_ff <= nxt_boost;
      end
   end

   assign pin_pull_up_en = pull_up_ff;
   assign pin_pull_down_en = pull_down_ff;
   assign pin_output_en = out_en_ff;
   assign pin_function_select = func_ff;
   assign port0_rail_select = rail_out_ff[PORT0_RAIL_MSB:PORT0_RAIL_LSB];
   assign port1_rail_select = rail_out_ff[PORT1_RAIL_MSB:PORT1_RAIL_LSB];
   assign rail_conflict = conflict_ff;

endmodule : pad_mode_and_rail_select
`default_nettype wire

// >>> testbench/pad_cfg_monitor.sv
// Purpose: bus and pad output checks. Assumes: one clock. Notes: bound from the bench
`default_nettype none
module pad_cfg_monitor
   import pad_cfg_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   input wire logic [ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [DATA_W-1:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   input wire logic [DATA_W-1:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic boost_mode,
   input wire logic [NUM_MODE-1:0] pin_pull_up_en,
   input wire logic [NUM_MODE-1:0] pin_pull_down_en,
   input wire logic [NUM_MODE-1:0] pin_output_en,
   input wire logic [NUM_MODE*5-1:0] pin_function_select,
   input wire logic [7:0] port0_rail_select,
   input wire logic [5:0] port1_rail_select,
   input wire logic rail_conflict
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   sequence s_ack; !avs_waitrequest && (avs_read || avs_write); endsequence
   property p_wait_pulse; !avs_waitrequest |=> avs_waitrequest; endproperty
   a_wait_pulse: assert property (p_wait_pulse) else $error("waitrequest low twice");
   property p_answer; (avs_read || avs_write) |-> ##[0:2] s_ack; endproperty
   a_answer: assert property (p_answer) else $error("access not answered");
   property p_excl;
      (pin_pull_up_en & pin_pull_down_en) == 4'h0 && (pin_output_en & pin_pull_up_en) == 4'h0;
   endproperty
   a_excl: assert property (p_excl) else $error("pad enables overlap");
   property p_rst_mode;
      $fell(rst) |=> pin_pull_down_en == 4'hf && (pin_pull_up_en | pin_output_en) == 4'h0;
   endproperty
   a_rst_mode: assert property (p_rst_mode) else $error("pin reset state wrong");
   property p_rst_func; $fell(rst) |=> pin_function_select == 20'h00000; endproperty
   a_rst_func: assert property (p_rst_func) else $error("function reset wrong");
   property p_rst_rail; $fell(rst) |=> {port1_rail_select, port0_rail_select} == 14'h0000; endproperty
   a_rst_rail: assert property (p_rst_rail) else $error("rail reset wrong");
   property p_rail_upd;
      $changed({port1_rail_select, port0_rail_select}) |-> $past(!avs_waitrequest && avs_write, 2);
   endproperty
   a_rail_upd: assert property (p_rail_upd) else $error("rail changed without write");
   property p_func_upd;
      $changed(pin_function_select) |-> $past(!avs_waitrequest && avs_write, 2);
   endproperty
   a_func_upd: assert property (p_func_upd) else $error("function changed without write");
   property p_read_hi; !avs_waitrequest && avs_read |-> avs_readdata[31:16] == 16'h0000; endproperty
   a_read_hi: assert property (p_read_hi) else $error("upper read bits set");
   property p_conflict;
      (((|port0_rail_select) || (|port1_rail_select)) && !boost_mode) [*6] |=> rail_conflict;
   endproperty
   a_conflict: assert property (p_conflict) else $error("buck rail use not flagged");
endmodule : pad_cfg_monitor
`default_nettype wire

// >>> testbench/pad_partner.sv
// Purpose: converter model. Assumes: bench picks the mode. Notes: mode settles slowly
`default_nettype none
module pad_partner (
   input wire logic clock,
   input wire logic boost_req,
   output logic boost_mode
);
   timeunit 1ns;
   timeprecision 1ns;
   logic settle_ff = 1'b0;
   always_ff @(posedge clock) begin
      settle_ff <= boost_req;
      boost_mode <= settle_ff;
   end
endmodule : pad_partner
`default_nettype wire

// >>> testbench/tb_pad_mode_and_rail_select.sv
// Purpose: register and pad tests. Assumes: avalon-mm. Notes: random with fixed seed
`default_nettype none
module tb_pad_mode_and_rail_select;
   import pad_cfg_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic [ADDR_W-1:0] avs_address = '0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [DATA_W-1:0] avs_writedata = '0;
   logic [3:0] avs_byteenable = 4'h0;
   logic [DATA_W-1:0] avs_readdata, rd, d, r;
   logic avs_waitrequest, boost_mode, rail_conflict, a;
   logic boost_req = 1'b0;
   logic [NUM_MODE-1:0] pin_pull_up_en, pin_pull_down_en, pin_output_en;
   logic [NUM_MODE*5-1:0] pin_function_select;
   logic [7:0] port0_rail_select;
   logic [5:0] port1_rail_select;
   int error_cnt = 0;
   int tests_run = 0;
   int cyc = 0;
   int p;
   always #10 clock = ~clock;
   pad_partner u_pad_partner (.clock, .boost_req, .boost_mode);
   pad_mode_and_rail_select u_pad_mode_and_rail_select (.clock, .rst, .avs_address, .avs_read,
      .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .boost_mode,
      .pin_pull_up_en, .pin_pull_down_en, .pin_output_en, .pin_function_select,
      .port0_rail_select, .port1_rail_select, .rail_conflict);
   task automatic end_sim();
      if (error_cnt == 0 && tests_run > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : end_sim
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic bus(input logic w, input logic [31:0] idx, input logic [31:0] wd);
      @(posedge clock);
      avs_address <= {idx[29:0], 2'b00};
      avs_read <= !w;
      avs_write <= w;
      avs_writedata <= wd;
      avs_byteenable <= 4'h3;
      do begin
         @(posedge clock);
      end while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask : bus
   function automatic logic [31:0] exp_en(input logic [15:0] v, input logic an);
      logic [1:0] dp;
      dp = an ? 2'h0 : v[9:8];
      return {29'h0, dp == DP_IN_UP, dp == DP_IN_DOWN, dp == DP_OUT};
   endfunction : exp_en
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         error_cnt++;
         end_sim();
      end
   end
   initial begin
      void'($urandom(84));
      repeat (12) @(posedge clock);
      rst <= 1'b0;
      for (int i = 0; i < 4; i++) begin
         bus(1'b0, IDX_PIN6_MODE + 2 * i, 32'h0);
         chk("mode_rst", 32'h00000200, rd);
      end
      bus(1'b0, IDX_RAIL_SEL, 32'h0);
      chk("rail_rst", 32'h00000000, rd);
      bus(1'b0, 32'h50003060, 32'h0);
      chk("unmapped", UNMAPPED_READ, rd);
      for (int k = 0; k < 24; k++) begin
         p = k % 4;
         d = $urandom();
         if (k < 4)
            d[9:8] = k[1:0];
         a = (k > 15);
         bus(1'b1, IDX_ANALOG_CTRL, {28'h0, {4{a}}});
         bus(1'b1, IDX_PIN6_MODE + 2 * p, d);
         bus(1'b0, IDX_PIN6_MODE + 2 * p, 32'h0);
         chk("mode_rd", d & MODE_MASK, rd);
         @(negedge clock);
         chk("pad_en", exp_en(d[15:0], a), {29'h0, pin_pull_up_en[p], pin_pull_down_en[p],
            pin_output_en[p]});
         chk("func", {27'h0, d[4:0]}, {27'h0, pin_function_select[p*5 +: 5]});
         r = $urandom();
         bus(1'b1, IDX_RAIL_SEL, r);
         bus(1'b0, IDX_RAIL_SEL, 32'h0);
         chk("rail_rd", r & RAIL_MASK, rd);
         @(negedge clock);
         chk("rail_out", {18'h0, r[13:0]}, {18'h0, port1_rail_select, port0_rail_select});
      end
      bus(1'b1, IDX_RAIL_SEL, 32'h00002001);
      repeat (10) @(posedge clock);
      chk("conflict", 32'h1, {31'h0, rail_conflict});
      boost_req <= 1'b1;
      repeat (10) @(posedge clock);
      chk("no_conflict", 32'h0, {31'h0, rail_conflict});
      bus(1'b0, IDX_PAD_STATUS, 32'h0);
      chk("status", 32'h00000004, rd);
      rst <= 1'b1;
      repeat (2) @(posedge clock);
      rst <= 1'b0;
      bus(1'b0, IDX_RAIL_SEL, 32'h0);
      chk("rail_rst2", 32'h00000000, rd);
      end_sim();
   end
endmodule : tb_pad_mode_and_rail_select
bind pad_mode_and_rail_select pad_cfg_monitor u_pad_cfg_monitor (.clock, .rst, .avs_address,
   .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
   .boost_mode, .pin_pull_up_en, .pin_pull_down_en, .pin_output_en, .pin_function_select,
   .port0_rail_select, .port1_rail_select, .rail_conflict);
`default_nettype wire
